/* File: core/ddr_burst2_pkg.sv */
// Purpose: shared constants for the burst-of-two double-data-rate SRAM port
// Assumes: one ref_clk_i edge per clock half; even edges are true-clock rises
// Notes:   pipeline indices count edges since the command edge, minus one
package ddr_burst2_pkg;

  // data path geometry
  localparam int DATA_W     = 18;
  localparam int LANE_W     = 9;
  localparam int LANES      = 2;
  localparam int WORD_W     = 2 * DATA_W;
  localparam int ADDR_W     = 21;
  localparam int FIFO_DEPTH = 8;

  // pipeline positions, in half-cycles after the command edge
  localparam int PIPE_DEPTH     = 7;
  localparam int WR_BEAT1_IDX   = 1;
  localparam int WR_BEAT2_IDX   = 2;
  localparam int RD_FETCH_IDX   = 3;
  localparam int RD_BEAT1_IDX   = 4;
  localparam int RD_BEAT2_IDX   = 5;
  localparam int TERM_OFF_FIRST = 3;
  localparam int TERM_OFF_LAST  = 6;

  // impedance calibration
  localparam int          CODE_W         = 6;
  localparam logic [5:0]  CODE_RESET     = 6'h20;
  localparam logic [5:0]  CODE_MAX       = 6'h3F;
  localparam logic [5:0]  CODE_MIN       = 6'h00;
  localparam int          CAL_PERIOD_CYC = 1024;

  // command decode
  typedef enum logic [1:0] {
    CMD_DESELECT = 2'b00,
    CMD_READ     = 2'b01,
    CMD_WRITE    = 2'b10
  } cmd_e;

endpackage

/* File: core/ddr_burst2_sram_port.sv */
// Purpose: device-side logic of a common-I/O burst-of-two DDR SRAM port
// Assumes: ref_clk_i runs at twice the SRAM clock, one edge per data beat
// Notes:   the read data FIFO sits between array fetch and output drivers
`timescale 1ns/1ps
`default_nettype none

module ddr_burst2_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  logic             do_push;
  logic             do_pop;

  assign in_ready_o  = (count != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign do_push     = in_valid_i & in_ready_o;
  assign do_pop      = out_valid_o & out_ready_i;
  assign out_data_o  = store[rd_ptr];

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  always_ff @(posedge ref_clk_i) begin
    if (do_push) begin
      store[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (do_pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      if (do_push && !do_pop) begin
        count <= count + (PTR_W+1)'(1);
      end else if (do_pop && !do_push) begin
        count <= count - (PTR_W+1)'(1);
      end
    end
  end

endmodule

module ddr_burst2_sram_port #(
  parameter int ADDR_W         = ddr_burst2_pkg::ADDR_W,
  parameter int CAL_PERIOD_CYC = ddr_burst2_pkg::CAL_PERIOD_CYC
) (
  // clock and reset
  input  wire logic                                ref_clk_i,
  input  wire logic                                rst_i,
  // command and address
  input  wire logic [ADDR_W-1:0]                   sync_address_in_i,
  input  wire logic                                load_command_n_i,
  input  wire logic                                read_not_write_i,
  // write data and byte lanes
  input  wire logic [ddr_burst2_pkg::DATA_W-1:0]   data_in_i,
  input  wire logic [ddr_burst2_pkg::LANES-1:0]    byte_lane_write_mask_n_i,
  // read data bus side
  output logic      [ddr_burst2_pkg::DATA_W-1:0]   data_out_o,
  output logic                                     data_oe_o,
  output logic                                     read_data_valid_out_o,
  output logic                                     echo_clock_out_o,
  // termination
  input  wire logic                                termination_enable_i,
  output logic                                     dq_termination_on_o,
  output logic                                     mask_clock_termination_on_o,
  // impedance calibration
  input  wire logic                                impedance_stronger_i,
  input  wire logic                                impedance_weaker_i,
  output logic      [ddr_burst2_pkg::CODE_W-1:0]   drive_code_o,
  output logic                                     cal_strobe_o,
  // pll control
  input  wire logic                                pll_disable_n_i,
  output logic                                     pll_enable_o
);

  localparam int DW  = ddr_burst2_pkg::DATA_W;
  localparam int LW  = ddr_burst2_pkg::LANE_W;
  localparam int NL  = ddr_burst2_pkg::LANES;
  localparam int WW  = ddr_burst2_pkg::WORD_W;
  localparam int PD  = ddr_burst2_pkg::PIPE_DEPTH;
  localparam int CNT_W = $clog2(CAL_PERIOD_CYC + 1);
  localparam int CW  = ddr_burst2_pkg::CODE_W;

  logic [WW-1:0]     mem [2**ADDR_W];

  logic              true_edge;
  ddr_burst2_pkg::cmd_e cmd;
  logic              rd_accept;
  logic              wr_accept;
  logic [PD-1:0]     rd_sh;
  logic [PD-1:0]     wr_sh;
  logic [ADDR_W-1:0] addr_sh [PD];
  logic [DW-1:0]     beat1_data;
  logic [NL-1:0]     beat1_mask_n;
  logic              next_oe;
  logic              next_term_off;
  logic              term_off;
  logic [CNT_W-1:0]  cal_count;
  logic              cal_fire;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [WW-1:0]     fifo_head;
  logic              fifo_pop;
  logic [WW-1:0]     fetch_word;

  // command decode; load high forces deselect whatever read_not_write says
  function automatic ddr_burst2_pkg::cmd_e decode_cmd(input logic load_n, input logic rnw);
    if (load_n) begin
      decode_cmd = ddr_burst2_pkg::CMD_DESELECT;
    end else if (rnw) begin
      decode_cmd = ddr_burst2_pkg::CMD_READ;
    end else begin
      decode_cmd = ddr_burst2_pkg::CMD_WRITE;
    end
  endfunction

  // per-lane merge of one beat; a high mask keeps the stored byte
  function automatic logic [DW-1:0] merge_beat(input logic [DW-1:0] old_d,
                                               input logic [DW-1:0] new_d,
                                               input logic [NL-1:0] mask_n);
    logic [DW-1:0] r;
    r = old_d;
    for (int l = 0; l < NL; l++) begin
      if (!mask_n[l]) begin
        r[l*LW +: LW] = new_d[l*LW +: LW];
      end
    end
    merge_beat = r;
  endfunction

  // clock phase: low marks a true-clock rise, high a complement rise
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      echo_clock_out_o <= 1'b0;
    end else begin
      echo_clock_out_o <= ~echo_clock_out_o;
    end
  end

  assign true_edge = ~echo_clock_out_o;
  assign cmd       = decode_cmd(load_command_n_i, read_not_write_i);

  // a read is only taken while the read buffer has room, so it never overflows
  assign rd_accept = true_edge && (cmd == ddr_burst2_pkg::CMD_READ) && fifo_in_ready;
  assign wr_accept = true_edge && (cmd == ddr_burst2_pkg::CMD_WRITE);

  // command pipelines, one stage per half-cycle; idle enters as zeros
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_sh <= '0;
      wr_sh <= '0;
    end else begin
      rd_sh <= {rd_sh[PD-2:0], rd_accept};
      wr_sh <= {wr_sh[PD-2:0], wr_accept};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    addr_sh[0] <= sync_address_in_i;
    for (int i = 1; i < PD; i++) begin
      addr_sh[i] <= addr_sh[i-1];
    end
  end

  // first write beat and its masks, taken at the true edge after the command
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      beat1_data   <= '0;
      beat1_mask_n <= '1;
    end else if (wr_sh[ddr_burst2_pkg::WR_BEAT1_IDX]) begin
      beat1_data   <= data_in_i;
      beat1_mask_n <= byte_lane_write_mask_n_i;
    end
  end

  // second beat lands at the complement edge; both beats go in as one word
  always_ff @(posedge ref_clk_i) begin
    if (wr_sh[ddr_burst2_pkg::WR_BEAT2_IDX] &&
        !((&beat1_mask_n) && (&byte_lane_write_mask_n_i))) begin
      mem[addr_sh[ddr_burst2_pkg::WR_BEAT2_IDX]] <= {
        merge_beat(mem[addr_sh[ddr_burst2_pkg::WR_BEAT2_IDX]][WW-1:DW],
                   data_in_i, byte_lane_write_mask_n_i),
        merge_beat(mem[addr_sh[ddr_burst2_pkg::WR_BEAT2_IDX]][DW-1:0],
                   beat1_data, beat1_mask_n)};
    end
  end

  // fetch late so an earlier write to the same word is already in the array
  assign fetch_word = mem[addr_sh[ddr_burst2_pkg::RD_FETCH_IDX]];

  assign fifo_pop = rd_sh[ddr_burst2_pkg::RD_BEAT2_IDX];

  ddr_burst2_fifo #(
    .WIDTH (WW),
    .DEPTH (ddr_burst2_pkg::FIFO_DEPTH)
  ) u_read_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (rd_sh[ddr_burst2_pkg::RD_FETCH_IDX]),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fetch_word),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_head)
  );

  // output beats: low half first, high half second, then the word is dropped
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      data_out_o <= '0;
    end else if (rd_sh[ddr_burst2_pkg::RD_BEAT1_IDX] && fifo_out_valid) begin
      data_out_o <= fifo_head[DW-1:0];
    end else if (rd_sh[ddr_burst2_pkg::RD_BEAT2_IDX] && fifo_out_valid) begin
      data_out_o <= fifo_head[WW-1:DW];
    end
  end

  // drivers on only for the two read beats; write and idle float 2.5 cycles on
  always_comb begin
    next_oe = rd_sh[ddr_burst2_pkg::RD_BEAT1_IDX] | rd_sh[ddr_burst2_pkg::RD_BEAT2_IDX];
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      data_oe_o             <= 1'b0;
      read_data_valid_out_o <= 1'b0;
    end else begin
      data_oe_o             <= next_oe;
      read_data_valid_out_o <= next_oe;
    end
  end

  // data termination drops one half-cycle before driving, returns one after
  always_comb begin
    next_term_off = 1'b0;
    for (int i = ddr_burst2_pkg::TERM_OFF_FIRST; i <= ddr_burst2_pkg::TERM_OFF_LAST; i++) begin
      next_term_off = next_term_off | rd_sh[i];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      term_off <= 1'b0;
    end else begin
      term_off <= next_term_off;
    end
  end

  assign dq_termination_on_o         = termination_enable_i & ~term_off;
  assign mask_clock_termination_on_o = termination_enable_i;

  // calibration period counter, restarts after each evaluation
  assign cal_fire = (cal_count == CNT_W'(CAL_PERIOD_CYC - 1));

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cal_count <= '0;
    end else if (cal_fire) begin
      cal_count <= '0;
    end else begin
      cal_count <= cal_count + CNT_W'(1);
    end
  end

  // one binary step per evaluation; a contradictory compare holds the code
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      drive_code_o <= ddr_burst2_pkg::CODE_RESET;
      cal_strobe_o <= 1'b0;
    end else begin
      cal_strobe_o <= cal_fire;
      if (cal_fire && impedance_stronger_i && !impedance_weaker_i &&
          drive_code_o != ddr_burst2_pkg::CODE_MAX) begin
        drive_code_o <= drive_code_o + CW'(1);
      end else if (cal_fire && impedance_weaker_i && !impedance_stronger_i &&
                   drive_code_o != ddr_burst2_pkg::CODE_MIN) begin
        drive_code_o <= drive_code_o - CW'(1);
      end
    end
  end

  // pll follows its disable pin, taken as a synchronous level
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pll_enable_o <= 1'b0;
    end else begin
      pll_enable_o <= pll_disable_n_i;
    end
  end

endmodule

`default_nettype wire

/* File: test/ddr_burst2_sram_port_sva.sv */
// Purpose: pin-level assertions for the burst-of-two SRAM port
// Assumes: read FIFO never fills under legal traffic
// Notes:   bound into every instance of the port
`timescale 1ns/1ps
`default_nettype none
module ddr_burst2_sram_port_sva #(
  parameter int ADDR_W         = 21,
  parameter int CAL_PERIOD_CYC = 1024
) (
  // clock, reset, command and write data
  input wire logic              ref_clk_i,
  input wire logic              rst_i,
  input wire logic [ADDR_W-1:0] sync_address_in_i,
  input wire logic              load_command_n_i,
  input wire logic              read_not_write_i,
  input wire logic [17:0]       data_in_i,
  input wire logic [1:0]        byte_lane_write_mask_n_i,
  // read side and termination
  input wire logic [17:0]       data_out_o,
  input wire logic              data_oe_o,
  input wire logic              read_data_valid_out_o,
  input wire logic              echo_clock_out_o,
  input wire logic              termination_enable_i,
  input wire logic              dq_termination_on_o,
  input wire logic              mask_clock_termination_on_o,
  // calibration and pll
  input wire logic              impedance_stronger_i,
  input wire logic              impedance_weaker_i,
  input wire logic [5:0]        drive_code_o,
  input wire logic              cal_strobe_o,
  input wire logic              pll_disable_n_i,
  input wire logic              pll_enable_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  logic rd_cmd;
  int   gap;
  logic seen;
  assign rd_cmd = !echo_clock_out_o && !load_command_n_i && read_not_write_i;

  // period is only judged between two strobes, the first one follows reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      gap  <= 0;
      seen <= 1'b0;
    end else if (cal_strobe_o) begin
      gap  <= 1;
      seen <= 1'b1;
    end else begin
      gap <= gap + 1;
    end
  end

  property p_rd_lat;
    rd_cmd |-> ##6 data_oe_o ##1 data_oe_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read beats late or missing");
  property p_oe_cause;
    $rose(data_oe_o) |-> $past(rd_cmd, 6);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven without a read");
  property p_idle_gap;
    (!echo_clock_out_o && !rd_cmd) |-> ##6 !data_oe_o ##1 !data_oe_o;
  endproperty
  a_idle_gap: assert property (p_idle_gap) else $error("drivers on after write or idle");
  property p_vld;
    read_data_valid_out_o == data_oe_o;
  endproperty
  a_vld: assert property (p_vld) else $error("valid differs from drive window");
  property p_mc_term;
    mask_clock_termination_on_o == termination_enable_i;
  endproperty
  a_mc_term: assert property (p_mc_term) else $error("mask clock termination wrong");
  property p_term_en;
    !termination_enable_i |-> !dq_termination_on_o;
  endproperty
  a_term_en: assert property (p_term_en) else $error("termination on while disabled");
  property p_term_read;
    data_oe_o |-> !dq_termination_on_o;
  endproperty
  a_term_read: assert property (p_term_read) else $error("termination on while driving");
  property p_term_edges;
    termination_enable_i && $rose(data_oe_o) |-> !$past(dq_termination_on_o);
  endproperty
  a_term_edges: assert property (p_term_edges) else $error("termination not off ahead");
  property p_term_tail;
    termination_enable_i && $fell(data_oe_o) |-> !dq_termination_on_o ##1 dq_termination_on_o;
  endproperty
  a_term_tail: assert property (p_term_tail) else $error("termination restore timing");
  property p_code_step;
    $changed(drive_code_o) |-> 6'(drive_code_o - $past(drive_code_o)) == 6'h01
      || 6'($past(drive_code_o) - drive_code_o) == 6'h01;
  endproperty
  a_code_step: assert property (p_code_step) else $error("driver code moved by more than one");
  property p_code_strobe;
    $changed(drive_code_o) |-> cal_strobe_o;
  endproperty
  a_code_strobe: assert property (p_code_strobe) else $error("code changed outside evaluation");
  property p_cal_period;
    cal_strobe_o && seen |-> gap == CAL_PERIOD_CYC;
  endproperty
  a_cal_period: assert property (p_cal_period) else $error("evaluation period wrong");
  property p_pll;
    !pll_disable_n_i |=> !pll_enable_o;
  endproperty
  a_pll: assert property (p_pll) else $error("pll left on");

  c_read: cover property (rd_cmd ##6 data_oe_o);
  c_b2b: cover property (data_oe_o [*4]);
  c_code: cover property ($changed(drive_code_o));
endmodule

bind ddr_burst2_sram_port ddr_burst2_sram_port_sva #(
  .ADDR_W(ADDR_W),
  .CAL_PERIOD_CYC(CAL_PERIOD_CYC)
) sva_u (.*);
`default_nettype wire

/* File: test/sram_ctrl_model.sv */
// Purpose: memory controller model driving command and write beats
// Assumes: echo low means the next edge is a true-clock rise
// Notes:   address and write data lines not in use carry the inverse of their last value; masks return high
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_model #(
  parameter int ADDR_W = 4
) (
  input  wire logic              ref_clk_i,
  input  wire logic              echo_i,
  input  wire logic              oe_i,
  input  wire logic [17:0]       rd_data_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic                   load_n_o,
  output logic                   rnw_o,
  output logic      [17:0]       wr_data_o,
  output logic      [1:0]        mask_n_o
);
  logic [17:0] rd_q[$];
  int          n_oe = 0;
  initial begin
    addr_o    = '0;
    load_n_o  = 1'b1;
    rnw_o     = 1'b0;
    wr_data_o = 18'h00000;
    mask_n_o  = 2'h3;
  end
  always @(posedge ref_clk_i) begin
    if (oe_i === 1'b1) begin
      rd_q.push_back(rd_data_i);
      n_oe++;
    end
  end
  task automatic step();
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic cmd(input logic [ADDR_W-1:0] a, input logic rd);
    while (echo_i !== 1'b0) step();
    addr_o   = a;
    load_n_o = 1'b0;
    rnw_o    = rd;
    step();
    load_n_o = 1'b1;
    addr_o   = ~a;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [35:0] d, input logic [3:0] m);
    cmd(a, 1'b0);
    step();
    wr_data_o = d[17:0];
    mask_n_o  = m[1:0];
    step();
    wr_data_o = d[35:18];
    mask_n_o  = m[3:2];
    step();
    wr_data_o = ~wr_data_o;
    mask_n_o  = 2'h3;
  endtask
  // load stays high, so toggling read_not_write must be ignored
  task automatic idle(input int n);
    repeat (n) begin
      rnw_o = ~rnw_o;
      step();
    end
  endtask
endmodule
`default_nettype wire

/* File: test/ddr_burst2_sram_port_tb.sv */
// Purpose: self-checking bench for the burst-of-two SRAM port
// Assumes: short calibration period and narrow address for run time
// Notes:   expected words are rebuilt lane by lane from the masks
`timescale 1ns/1ps
`default_nettype none
module ddr_burst2_sram_port_tb;
  localparam int AW = 4;
  logic          ref_clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic [AW-1:0] sync_address_in_i;
  logic          load_command_n_i, read_not_write_i;
  logic [17:0]   data_in_i, data_out_o;
  logic [1:0]    byte_lane_write_mask_n_i;
  logic          data_oe_o, read_data_valid_out_o, echo_clock_out_o;
  logic          termination_enable_i = 1'b1;
  logic          dq_termination_on_o, mask_clock_termination_on_o;
  logic          impedance_stronger_i = 1'b0;
  logic          impedance_weaker_i = 1'b0;
  logic [5:0]    drive_code_o;
  logic          cal_strobe_o, pll_enable_o;
  logic          pll_disable_n_i = 1'b1;
  int            mismatches = 0;
  int            n_checks = 0;
  int            cycles = 0;

  ddr_burst2_sram_port #(.ADDR_W(AW), .CAL_PERIOD_CYC(8)) dut_u (.*);
  sram_ctrl_model #(.ADDR_W(AW)) ctrl_u (
    .ref_clk_i(ref_clk_i), .echo_i(echo_clock_out_o), .oe_i(data_oe_o), .rd_data_i(data_out_o),
    .addr_o(sync_address_in_i), .load_n_o(load_command_n_i), .rnw_o(read_not_write_i),
    .wr_data_o(data_in_i), .mask_n_o(byte_lane_write_mask_n_i));

  always #5 ref_clk_i = ~ref_clk_i;

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic t_reset_pll();
    check("drive_code", drive_code_o, 6'h20);
    check("pll_on", pll_enable_o, 1'b1);
    pll_disable_n_i = 1'b0;
    repeat (2) ctrl_u.step();
    check("pll_off", pll_enable_o, 1'b0);
    pll_disable_n_i = 1'b1;
    $display("test reset_pll done");
  endtask
  // masks differ between beats; the last write is fully masked
  task automatic t_masked_write();
    logic [35:0] exp [4];
    logic [35:0] nd;
    logic [3:0]  msk [4];
    msk = '{4'hC, 4'h6, 4'h9, 4'hF};
    for (int i = 0; i < 4; i++) begin
      exp[i] = 36'(36'h123456789 * (i + 1));
      ctrl_u.wr(i[AW-1:0], exp[i], 4'h0);
    end
    for (int i = 0; i < 4; i++) begin
      nd = ~exp[i];
      ctrl_u.wr(i[AW-1:0], nd, msk[i]);
      for (int l = 0; l < 4; l++) if (!msk[i][l]) exp[i][9*l +: 9] = nd[9*l +: 9];
    end
    ctrl_u.rd_q.delete();
    for (int i = 0; i < 4; i++) ctrl_u.cmd(i[AW-1:0], 1'b1);
    for (int k = 0; k < 40 && ctrl_u.rd_q.size() < 8; k++) ctrl_u.step();
    check("beats", ctrl_u.rd_q.size(), 8);
    for (int i = 0; i < 8 && i < ctrl_u.rd_q.size(); i++)
      check("read_beat", ctrl_u.rd_q[i], exp[i/2][18*(i%2) +: 18]);
    $display("test masked_write done");
  endtask
  task automatic t_deselect();
    int n0;
    ctrl_u.idle(10);
    n0 = ctrl_u.n_oe;
    ctrl_u.cmd(4'h1, 1'b1);
    ctrl_u.wr(4'h2, 36'h0, 4'h0);
    ctrl_u.idle(20);
    check("oe_cycles", ctrl_u.n_oe - n0, 2);
    $display("test deselect done");
  endtask
  task automatic t_term();
    int n_off;
    n_off = 0;
    ctrl_u.cmd(4'h0, 1'b1);
    repeat (14) begin
      ctrl_u.step();
      if (dq_termination_on_o === 1'b0) n_off++;
    end
    check("term_off_cycles", n_off, 4);
    check("mask_clock_term", mask_clock_termination_on_o, 1'b1);
    termination_enable_i = 1'b0;
    ctrl_u.cmd(4'h0, 1'b1);
    ctrl_u.step();
    check("dq_term_disabled", dq_termination_on_o, 1'b0);
    check("mask_term_disabled", mask_clock_termination_on_o, 1'b0);
    ctrl_u.idle(10);
    termination_enable_i = 1'b1;
    $display("test term done");
  endtask
  task automatic pulses(input int n);
    int s;
    s = 0;
    for (int k = 0; k < 12 * n && s < n; k++) begin
      ctrl_u.step();
      if (cal_strobe_o === 1'b1) s++;
    end
  endtask
  task automatic t_cal();
    pulses(1);
    impedance_stronger_i = 1'b1;
    pulses(3);
    impedance_stronger_i = 1'b0;
    check("code_up", drive_code_o, 6'h23);
    impedance_weaker_i = 1'b1;
    pulses(40);
    impedance_weaker_i = 1'b0;
    check("code_floor", drive_code_o, 6'h00);
    $display("test cal done");
  endtask

  initial begin
    repeat (12) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    repeat (2) ctrl_u.step();
    t_reset_pll();
    t_masked_write();
    t_deselect();
    t_term();
    t_cal();
    close_out();
  end
endmodule
`default_nettype wire
